// file: hdl/aio_pkg.sv
// package: parameter map, process-image layout and carrier types of the analog i/o control block
package aio_pkg;

    // ========================================================================
    // parameter set layout (byte offsets)
    localparam int unsigned        AIO_PAR_BYTES      = 12;
    localparam logic [3:0]         AIO_PAR_DIAG_WB    = 4'h0;
    localparam logic [3:0]         AIO_PAR_STOP_REACT = 4'h1;
    localparam logic [3:0]         AIO_PAR_FN_CH0     = 4'h2;
    localparam logic [3:0]         AIO_PAR_FN_CH3     = 4'h5;
    localparam logic [3:0]         AIO_PAR_RATE_CH0   = 4'h6;
    localparam logic [3:0]         AIO_PAR_RATE_CH1   = 4'h7;
    localparam logic [3:0]         AIO_PAR_SUB2_HI    = 4'h8;
    localparam logic [3:0]         AIO_PAR_SUB2_LO    = 4'h9;
    localparam logic [3:0]         AIO_PAR_SUB3_HI    = 4'hA;
    localparam logic [3:0]         AIO_PAR_SUB3_LO    = 4'hB;

    // ========================================================================
    // field positions
    localparam int unsigned        AIO_BIT_WB_CH0     = 0;
    localparam int unsigned        AIO_BIT_WB_CH1     = 1;
    localparam int unsigned        AIO_BIT_DIAG_IRQ   = 6;
    localparam int unsigned        AIO_BIT_HOLD_CH2   = 2;
    localparam int unsigned        AIO_BIT_HOLD_CH3   = 3;

    // ========================================================================
    // reset values (byte 0 in the top byte of the image)
    localparam logic [7:0]         AIO_RST_DIAG_WB    = 8'h00;
    localparam logic [7:0]         AIO_RST_STOP_REACT = 8'h00;
    localparam logic [7:0]         AIO_RST_FN_IN      = 8'h28;
    localparam logic [7:0]         AIO_RST_FN_OUT     = 8'h09;
    localparam logic [7:0]         AIO_RST_RATE       = 8'h00;
    localparam logic [7:0]         AIO_RST_SUB        = 8'h00;
    localparam logic [95:0]        AIO_PAR_RESET_IMAGE = {
        AIO_RST_DIAG_WB, AIO_RST_STOP_REACT, AIO_RST_FN_IN, AIO_RST_FN_IN,
        AIO_RST_FN_OUT, AIO_RST_FN_OUT, AIO_RST_RATE, AIO_RST_RATE,
        AIO_RST_SUB, AIO_RST_SUB, AIO_RST_SUB, AIO_RST_SUB};

    // writable bits per byte; reserved bits are stored as zero
    localparam logic [7:0]         AIO_MASK_DIAG_WB   = 8'h43;
    localparam logic [7:0]         AIO_MASK_STOP      = 8'h0C;
    localparam logic [7:0]         AIO_MASK_RATE      = 8'h0F;
    localparam logic [7:0]         AIO_MASK_FULL      = 8'hFF;
    localparam logic [95:0]        AIO_PAR_MASK_IMAGE = {
        AIO_MASK_DIAG_WB, AIO_MASK_STOP, AIO_MASK_FULL, AIO_MASK_FULL,
        AIO_MASK_FULL, AIO_MASK_FULL, AIO_MASK_RATE, AIO_MASK_RATE,
        AIO_MASK_FULL, AIO_MASK_FULL, AIO_MASK_FULL, AIO_MASK_FULL};

    // ========================================================================
    // function codes
    localparam logic [7:0]         AIO_FN_KEEP        = 8'h00;
    localparam logic [7:0]         AIO_FN_OFF         = 8'hFF;
    localparam logic [7:0]         AIO_FN_I_4_20MA    = 8'h2E;
    localparam logic [7:0]         AIO_FN_MULTIWIRE   = 8'h50;

    // ========================================================================
    // process image and diagnostic record sizes
    localparam logic [1:0]         AIO_DIAG_REC_LAST  = 2'h3;
    localparam logic [7:0]         AIO_BYTE_ZERO      = 8'h00;
    localparam logic [15:0]        AIO_WORD_ZERO      = 16'h0000;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic       en;
        logic [3:0] addr;
        logic [7:0] data;
    } aio_byte_wr_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } aio_sample_t;

endpackage

// file: hdl/aio_param_mem.sv
// retained parameter store: twelve bytes, one write port, registered read port
`timescale 1ns/1ps
`default_nettype none
module aio_param_mem (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    // read port
    input  wire logic [3:0]  rd_addr,
    output logic      [7:0]  rd_data,
    // whole set, byte 0 in the top byte
    output logic      [95:0] image
);
    import aio_pkg::*;

    logic [7:0] mem_q [AIO_PAR_BYTES];
    logic [7:0] mem_d [AIO_PAR_BYTES];
    logic [7:0] rd_d;

    // ========================================================================
    // storage, one entry per byte
    genvar gi;
    generate
        for (gi = 0; gi < AIO_PAR_BYTES; gi++) begin : g_entry
            always_comb begin
                mem_d[gi] = mem_q[gi];
                if (wr_en && wr_addr == 4'(gi)) begin
                    mem_d[gi] = wr_data;
                end
            end
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem_q[gi] <= AIO_PAR_RESET_IMAGE[95-8*gi -: 8];
                end else begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
            assign image[95-8*gi -: 8] = mem_q[gi];
        end
    endgenerate

    // ========================================================================
    // read port; unmapped bytes read zero
    always_comb begin
        rd_d = AIO_BYTE_ZERO;
        if (rd_addr < 4'(AIO_PAR_BYTES)) begin
            rd_d = mem_q[rd_addr];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= AIO_BYTE_ZERO;
        end else begin
            rd_data <= rd_d;
        end
    end

endmodule // aio_param_mem
`default_nettype wire

// file: hdl/aio_ctrl.sv
// analog i/o control: parameter handling, process image mapping, stop reaction, diagnostics
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] inputs appear as 16-bit words, high byte first, channel 0 then 1
// [RL2] controller writes output words high byte first, channel 2 then 3
// [RL3] three/four-wire mode uses channel 0 only; channel 1 reads zero
// [RL4] twelve-byte parameter set held in retained storage
// [RL5] byte 0 bits 0/1 enable wire-break detection per input, default off
// [RL6] byte 0 bit 6 gates diagnostic interrupt, default inhibited
// [RL7] at stop each output drives replacement (0) or holds last value (1)
// [RL8] bytes 8-11 hold replacement words high byte first, default zero
// [RL9] bytes 2-5 hold function codes; inputs default 28h, outputs 09h
// [RL10] bytes 6 and 7 select input conversion rates, default zero
// [RL11] code FFh turns a channel off: no measurement, no error
// [RL12] sum-fault indicator lit on any channel error or diagnostic entry
// [RL13] controller loads E500h or F000h for zero output at stop
// [RL14] parameters rewritable while running; diagnostics readable at runtime
// [RL15] wire break only in 4-20 mA range, flagged and recorded
// [RL16] enabled interrupt on error announces four-byte diagnostic record 0
// [RL17] rate field is bits 3..0, codes 0..7; bits 7..4 reserved
// [RL18] function code 00h leaves the stored code unchanged
// [RL19] reserved parameter bits are ignored and read back zero
module aio_ctrl (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    // parameter access from the controller
    input  wire aio_pkg::aio_byte_wr_t       par_wr,
    input  wire logic [3:0]                  par_rd_addr,
    output logic      [7:0]                  par_rd_data,
    // retained store restore and image
    input  wire aio_pkg::aio_byte_wr_t       nv_load,
    output logic      [95:0]                 par_image,
    output logic                             par_changed,
    // process image: outputs written, inputs read
    input  wire aio_pkg::aio_byte_wr_t       out_wr,
    input  wire logic [1:0]                  in_rd_addr,
    output logic      [7:0]                  in_rd_data,
    // diagnostics
    input  wire logic [1:0]                  diag_rd_addr,
    output logic      [7:0]                  diag_rd_data,
    input  wire logic                        diag_clear,
    output logic                             diag_irq,
    // controller run state
    input  wire logic                        cpu_stop,
    // converter side
    input  wire aio_pkg::aio_sample_t [1:0]  adc_sample,
    input  wire logic [1:0]                  wire_break_pin,
    output logic      [3:0]                  conv_rate_ch0,
    output logic      [3:0]                  conv_rate_ch1,
    output logic      [3:0]                  ch_active,
    output logic      [15:0]                 dac_value_ch2,
    output logic      [15:0]                 dac_value_ch3,
    // front panel
    output logic                             sum_fault_indicator
);
    import aio_pkg::*;

    function automatic logic [7:0] par_byte(input logic [95:0] img, input int unsigned idx);
        par_byte = img[95-8*idx -: 8];
    endfunction

    // ========================================================================
    // parameter write path
    aio_byte_wr_t wr_sel;
    logic         mem_wr_en;
    logic [7:0]   mem_wr_data;
    logic         fn_keep;
    logic [95:0]  img;
    logic         changed_d;
    logic         changed_q;

    always_comb begin
        // a restore from retained storage outranks a controller write
        wr_sel      = nv_load.en ? nv_load : par_wr; // [RL4] [RL14]
        fn_keep     = (wr_sel.addr >= AIO_PAR_FN_CH0) && (wr_sel.addr <= AIO_PAR_FN_CH3)
                      && (wr_sel.data == AIO_FN_KEEP); // [RL18]
        mem_wr_en   = wr_sel.en && (wr_sel.addr < 4'(AIO_PAR_BYTES)) && !fn_keep;
        mem_wr_data = AIO_BYTE_ZERO;
        if (wr_sel.addr < 4'(AIO_PAR_BYTES)) begin
            mem_wr_data = wr_sel.data & par_byte(AIO_PAR_MASK_IMAGE, 32'(wr_sel.addr)); // [RL19]
        end
        changed_d   = mem_wr_en;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            changed_q <= 1'b0;
        end else begin
            changed_q <= changed_d;
        end
    end

    aio_param_mem u_param_mem (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr_en   (mem_wr_en),
        .wr_addr (wr_sel.addr),
        .wr_data (mem_wr_data),
        .rd_addr (par_rd_addr),
        .rd_data (par_rd_data),
        .image   (img)
    ); // [RL4] [RL9] [RL8] [RL10]

    assign par_image   = img;
    assign par_changed = changed_q;

    // ========================================================================
    // decoded parameter fields
    logic [7:0]  fn_code [4];
    logic [3:0]  chan_on;
    logic        multiwire;
    logic [1:0]  wb_enable;
    logic        irq_enable;
    logic [1:0]  hold_last;
    logic [15:0] sub_word [2];
    logic [7:0]  cfg_b [2];
    logic [7:0]  rate_b [2];

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            fn_code[c] = par_byte(img, 32'(AIO_PAR_FN_CH0) + 32'(c));
            chan_on[c] = (fn_code[c] != AIO_FN_OFF); // [RL11]
        end
        multiwire  = chan_on[0] && (fn_code[0] == AIO_FN_MULTIWIRE); // [RL3]
        cfg_b[0]   = par_byte(img, 32'(AIO_PAR_DIAG_WB));
        cfg_b[1]   = par_byte(img, 32'(AIO_PAR_STOP_REACT));
        rate_b[0]  = par_byte(img, 32'(AIO_PAR_RATE_CH0));
        rate_b[1]  = par_byte(img, 32'(AIO_PAR_RATE_CH1));
        wb_enable  = {cfg_b[0][AIO_BIT_WB_CH1], cfg_b[0][AIO_BIT_WB_CH0]}; // [RL5]
        irq_enable = cfg_b[0][AIO_BIT_DIAG_IRQ]; // [RL6]
        hold_last  = {cfg_b[1][AIO_BIT_HOLD_CH3], cfg_b[1][AIO_BIT_HOLD_CH2]}; // [RL7]
        sub_word[0] = {par_byte(img, 32'(AIO_PAR_SUB2_HI)), par_byte(img, 32'(AIO_PAR_SUB2_LO))}; // [RL8]
        sub_word[1] = {par_byte(img, 32'(AIO_PAR_SUB3_HI)), par_byte(img, 32'(AIO_PAR_SUB3_LO))}; // [RL8]
    end

    // rate field passed on unchanged in its four bits; upper nibble never stored
    assign conv_rate_ch0 = rate_b[0][3:0]; // [RL10] [RL17]
    assign conv_rate_ch1 = rate_b[1][3:0]; // [RL10] [RL17]
    assign ch_active     = {chan_on[3], chan_on[2], chan_on[1] && !multiwire, chan_on[0]};

    // ========================================================================
    // input process image
    logic [15:0] in_word_q [2];
    logic [15:0] in_word_d [2];
    logic [7:0]  in_rd_d;
    logic [7:0]  in_rd_q;
    logic [1:0]  in_used;

    assign in_used = {chan_on[1] && !multiwire, chan_on[0]}; // [RL3] [RL11]

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            always_comb begin
                in_word_d[gi] = in_word_q[gi];
                if (!in_used[gi]) begin
                    in_word_d[gi] = AIO_WORD_ZERO; // [RL3] [RL11]
                end else if (adc_sample[gi].valid) begin
                    in_word_d[gi] = adc_sample[gi].data;
                end
            end
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    in_word_q[gi] <= AIO_WORD_ZERO;
                end else begin
                    in_word_q[gi] <= in_word_d[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        case (in_rd_addr)
            2'h0:    in_rd_d = in_word_q[0][15:8]; // [RL1]
            2'h1:    in_rd_d = in_word_q[0][7:0];
            2'h2:    in_rd_d = in_word_q[1][15:8];
            2'h3:    in_rd_d = in_word_q[1][7:0];
            default: in_rd_d = AIO_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_rd_q <= AIO_BYTE_ZERO;
        end else begin
            in_rd_q <= in_rd_d;
        end
    end

    assign in_rd_data = in_rd_q;

    // ========================================================================
    // output process image and stop reaction
    logic [15:0] out_word_q [2];
    logic [15:0] out_word_d [2];
    logic [1:0]  out_seen_q;
    logic [1:0]  out_seen_d;
    logic [15:0] dac_q [2];
    logic [15:0] dac_d [2];

    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            always_comb begin
                out_word_d[gi] = out_word_q[gi];
                out_seen_d[gi] = out_seen_q[gi];
                // byte 2*ch is the high byte, 2*ch+1 the low byte
                if (out_wr.en && out_wr.addr[3:2] == 2'h0 && out_wr.addr[1] == 1'(gi)) begin
                    if (!out_wr.addr[0]) begin
                        out_word_d[gi][15:8] = out_wr.data; // [RL2]
                    end else begin
                        out_word_d[gi][7:0] = out_wr.data; // [RL2]
                    end
                    out_seen_d[gi] = 1'b1;
                end
                // until the controller has written, a reset leaves the replacement value
                if (!chan_on[gi+2]) begin
                    dac_d[gi] = AIO_WORD_ZERO; // [RL11]
                end else if (cpu_stop) begin
                    dac_d[gi] = hold_last[gi] ? dac_q[gi] : sub_word[gi]; // [RL7]
                end else begin
                    dac_d[gi] = out_seen_q[gi] ? out_word_q[gi] : sub_word[gi];
                end
            end
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    out_word_q[gi] <= AIO_WORD_ZERO;
                    out_seen_q[gi] <= 1'b0;
                    dac_q[gi]      <= AIO_WORD_ZERO;
                end else begin
                    out_word_q[gi] <= out_word_d[gi];
                    out_seen_q[gi] <= out_seen_d[gi];
                    dac_q[gi]      <= dac_d[gi];
                end
            end
        end
    endgenerate

    assign dac_value_ch2 = dac_q[0];
    assign dac_value_ch3 = dac_q[1];

    // ========================================================================
    // wire-break detection and diagnostics
    logic [1:0] wb_meta_q;
    logic [1:0] wb_sync_q;
    logic [1:0] wb_event;
    logic [1:0] wb_flag_q;
    logic [1:0] wb_flag_d;
    logic       irq_d;
    logic       irq_q;
    logic [7:0] diag_rd_d;
    logic [7:0] diag_rd_q;
    logic       fault_any;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            // only the 4-20 mA range can see a break; an off channel never errs
            wb_event[c] = wb_sync_q[c] && wb_enable[c] && in_used[c]
                          && (fn_code[c] == AIO_FN_I_4_20MA); // [RL15] [RL5] [RL11]
            // a new break wins over a clear in the same cycle
            wb_flag_d[c] = wb_event[c] || (wb_flag_q[c] && !diag_clear);
        end
        fault_any = |wb_flag_q;
        irq_d     = irq_enable && |(wb_event & ~wb_flag_q); // [RL6] [RL16]
        case (diag_rd_addr)
            2'h0:    diag_rd_d = {5'h00, fault_any, 1'b0, fault_any};
            2'h1:    diag_rd_d = AIO_BYTE_ZERO;
            2'h2:    diag_rd_d = {6'h00, wb_flag_q}; // [RL14] [RL16]
            default: diag_rd_d = AIO_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_meta_q <= 2'h0;
            wb_sync_q <= 2'h0;
            wb_flag_q <= 2'h0;
            irq_q     <= 1'b0;
            diag_rd_q <= AIO_BYTE_ZERO;
        end else begin
            wb_meta_q <= wire_break_pin;
            wb_sync_q <= wb_meta_q;
            wb_flag_q <= wb_flag_d;
            irq_q     <= irq_d;
            diag_rd_q <= diag_rd_d;
        end
    end

    assign diag_irq            = irq_q; // [RL16]
    assign diag_rd_data        = diag_rd_q;
    assign sum_fault_indicator = fault_any; // [RL12]

endmodule // aio_ctrl
`default_nettype wire

// file: testbench/aio_ctrl_props.sv
// checker: port-level properties of the analog i/o control block
`timescale 1ns/1ps
`default_nettype none
module aio_ctrl_props (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    // parameter side
    input wire aio_pkg::aio_byte_wr_t par_wr,
    input wire aio_pkg::aio_byte_wr_t nv_load,
    input wire logic [95:0]           par_image,
    input wire logic                  par_changed,
    // run state and channels
    input wire logic                  cpu_stop,
    input wire logic [1:0]            wire_break_pin,
    input wire logic [3:0]            conv_rate_ch0,
    input wire logic [3:0]            ch_active,
    input wire logic [15:0]           dac_value_ch2,
    input wire logic [15:0]           dac_value_ch3,
    // diagnostics
    input wire logic                  diag_irq,
    input wire logic                  sum_fault_indicator
);
    import aio_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ========================================================================
    // parameter store
    write_pulse_a: assert property (par_wr.en && par_wr.addr == 4'h6 |=> par_changed)
        else $error("no change pulse");
    range_drop_a: assert property (par_wr.en && par_wr.addr > 4'hB && !nv_load.en
        |=> !par_changed)
        else $error("stray write taken");
    code_keep_a: assert property (par_wr.en && par_wr.addr == 4'h2 && par_wr.data == 8'h00
        && !nv_load.en |=> $stable(par_image[79:72]))
        else $error("code 00h stored");
    reserved_zero_a: assert property ((par_image[95:88] & 8'hBC) == 8'h00
        && (par_image[87:80] & 8'hF3) == 8'h00 && par_image[47:44] == 4'h0)
        else $error("reserved bit set");
    rate_field_a: assert property (conv_rate_ch0 == par_image[43:40])
        else $error("rate field wrong");
    chan_off_a: assert property (ch_active[0] == (par_image[79:72] != 8'hFF)
        && ch_active[3] == (par_image[55:48] != 8'hFF))
        else $error("activity wrong");
    // ========================================================================
    // stop reaction and diagnostics
    stop_subst_a: assert property (cpu_stop && !par_image[82] && ch_active[2]
        |=> dac_value_ch2 == $past(par_image[31:16]))
        else $error("no replacement");
    stop_hold_a: assert property (cpu_stop && par_image[83] && ch_active[3]
        |=> $stable(dac_value_ch3))
        else $error("held output moved at stop");
    irq_gate_a: assert property (diag_irq |-> $past(par_image[94]) && sum_fault_indicator)
        else $error("stray interrupt");
    break_flag_a: assert property ((wire_break_pin[0] && par_image[88]
        && par_image[79:72] == 8'h2E) [*3] |=> sum_fault_indicator)
        else $error("wire break not flagged");
    cover property (cpu_stop && par_image[83]);
    cover property (diag_irq);
    cover property (par_changed);
endmodule // aio_ctrl_props

bind aio_ctrl aio_ctrl_props u_props (.sys_clk, .reset_n, .par_wr, .nv_load,
    .par_image, .par_changed, .cpu_stop, .wire_break_pin, .conv_rate_ch0,
    .ch_active, .dac_value_ch2, .dac_value_ch3, .diag_irq, .sum_fault_indicator);
`default_nettype wire

// file: testbench/aio_host.sv
// controller model: parameter, output-area and read-address requests
`timescale 1ns/1ps
`default_nettype none
module aio_host (
    // clock
    input  wire logic                 sys_clk,
    // write requests
    output var aio_pkg::aio_byte_wr_t par_wr,
    output var aio_pkg::aio_byte_wr_t out_wr,
    // read addresses and answers
    output var logic [3:0]            par_rd_addr,
    output var logic [1:0]            in_rd_addr,
    output var logic [1:0]            diag_rd_addr,
    input  wire logic [7:0]           par_rd_data,
    input  wire logic [7:0]           in_rd_data,
    input  wire logic [7:0]           diag_rd_data
);
    import aio_pkg::*;
    initial begin
        par_wr = '0;
        out_wr = '0;
        par_rd_addr = 4'h0;
        in_rd_addr = 2'h0;
        diag_rd_addr = 2'h0;
    end
    // ========================================================================
    // released data shows the inverse so a stale byte is never mistaken
    task automatic pwr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk) par_wr <= {1'b1, a, d};
        @(posedge sys_clk) par_wr <= {1'b0, a, ~d};
    endtask
    task automatic owr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk) out_wr <= {1'b1, a, d};
        @(posedge sys_clk) out_wr <= {1'b0, a, ~d};
    endtask
    task automatic rd(input int s, input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        case (s)
            0: par_rd_addr <= a;
            1: in_rd_addr <= a[1:0];
            default: diag_rd_addr <= a[1:0];
        endcase
        @(posedge sys_clk);
        #1;
        d = (s == 0) ? par_rd_data : (s == 1) ? in_rd_data : diag_rd_data;
    endtask
endmodule // aio_host
`default_nettype wire

// file: testbench/tb_aio_ctrl.sv
// testbench: parameter map, process image, stop reaction and diagnostics
`timescale 1ns/1ps
`default_nettype none
module tb_aio_ctrl;
    import aio_pkg::*;
    logic                  sys_clk, reset_n, diag_clear, cpu_stop, par_changed, diag_irq;
    logic                  sum_fault_indicator;
    aio_byte_wr_t          par_wr, nv_load, out_wr;
    aio_sample_t [1:0]     adc_sample;
    logic [3:0]            par_rd_addr, conv_rate_ch0, conv_rate_ch1, ch_active;
    logic [1:0]            in_rd_addr, diag_rd_addr, wire_break_pin;
    logic [7:0]            par_rd_data, in_rd_data, diag_rd_data;
    logic [95:0]           par_image;
    logic [15:0]           dac_value_ch2, dac_value_ch3;
    int                    fails, num_checks, i, k;
    localparam logic [95:0] DFLT = 96'h0000_2828_0909_0000_0000_0000;

    always #2.5 sys_clk = ~sys_clk;

    aio_host host (.sys_clk, .par_wr, .out_wr, .par_rd_addr, .in_rd_addr, .diag_rd_addr,
        .par_rd_data, .in_rd_data, .diag_rd_data);
    aio_ctrl dut (.sys_clk, .reset_n, .par_wr, .par_rd_addr, .par_rd_data, .nv_load,
        .par_image, .par_changed, .out_wr, .in_rd_addr, .in_rd_data, .diag_rd_addr,
        .diag_rd_data, .diag_clear, .diag_irq, .cpu_stop, .adc_sample, .wire_break_pin,
        .conv_rate_ch0, .conv_rate_ch1, .ch_active, .dac_value_ch2, .dac_value_ch3,
        .sum_fault_indicator);

    // ========================================================================
    // checking helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input int s, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] b;
        host.rd(s, a, b);
        chk("read byte", {8'h00, e}, {8'h00, b});
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic conclude();
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ========================================================================
    // main sequence
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        nv_load = '0;
        diag_clear = 1'b0;
        cpu_stop = 1'b0;
        adc_sample = '0;
        wire_break_pin = 2'b00;
        fails = 0;
        num_checks = 0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 12; i++)
            rchk(0, i[3:0], DFLT[95-8*i -: 8]);
        rchk(0, 4'hC, 8'h00);
        host.pwr(4'h0, 8'hFF);
        rchk(0, 4'h0, 8'h43);
        host.pwr(4'h1, 8'hFF);
        rchk(0, 4'h1, 8'h0C);
        host.pwr(4'h6, 8'hF3);
        rchk(0, 4'h6, 8'h03);
        host.pwr(4'h2, 8'h00);
        rchk(0, 4'h2, 8'h28);
        // restore path from retained storage
        @(posedge sys_clk) nv_load <= {1'b1, 4'h7, 8'h05};
        @(posedge sys_clk) nv_load <= {1'b0, 4'h7, 8'hFA};
        rchk(0, 4'h7, 8'h05);
        // input area
        @(posedge sys_clk) adc_sample <= {1'b1, 16'h1357, 1'b1, 16'hABCD};
        @(posedge sys_clk) adc_sample <= '0;
        for (i = 0; i < 4; i++)
            rchk(1, i[3:0], 8'(32'hABCD1357 >> (24 - 8 * i)));
        host.pwr(4'h2, 8'h50);
        rchk(1, 4'h2, 8'h00);
        rchk(1, 4'h3, 8'h00);
        host.pwr(4'h2, 8'h28);
        host.pwr(4'h3, 8'hFF);
        @(posedge sys_clk) adc_sample <= {1'b1, 16'h2468, 1'b0, 16'h0000};
        @(posedge sys_clk) adc_sample <= '0;
        rchk(1, 4'h2, 8'h00);
        chk("active", 16'h000D, {12'h000, ch_active});
        host.pwr(4'h3, 8'h28);
        // output area, then stop with replacement on ch2 and hold on ch3
        host.owr(4'h0, 8'h12);
        host.owr(4'h1, 8'h34);
        host.owr(4'h2, 8'h56);
        host.owr(4'h3, 8'h78);
        host.owr(4'h4, 8'hFF);
        edges(2);
        chk("dac2", 16'h1234, dac_value_ch2);
        chk("dac3", 16'h5678, dac_value_ch3);
        host.pwr(4'h8, 8'hE5);
        host.pwr(4'h9, 8'h00);
        host.pwr(4'h1, 8'h08);
        @(posedge sys_clk) cpu_stop <= 1'b1;
        host.owr(4'h2, 8'hAA);
        edges(2);
        chk("dac2 stop", 16'hE500, dac_value_ch2);
        chk("dac3 stop", 16'h5678, dac_value_ch3);
        @(posedge sys_clk) cpu_stop <= 1'b0;
        edges(3);
        chk("dac3 run", 16'hAA78, dac_value_ch3);
        // wire break: ch1 disabled by its enable bit, ch0 enabled with interrupt
        host.pwr(4'h3, 8'h2E);
        host.pwr(4'h0, 8'h41);
        host.pwr(4'h2, 8'h2E);
        @(posedge sys_clk) wire_break_pin <= 2'b10;
        edges(6);
        chk("fault off", 16'h0000, {15'h0000, sum_fault_indicator});
        @(posedge sys_clk) wire_break_pin <= 2'b01;
        k = 0;
        do begin
            edges(1);
            k++;
        end while (diag_irq !== 1'b1 && k < 10);
        if (diag_irq !== 1'b1) begin
            fails++;
            conclude();
        end
        chk("fault on", 16'h0001, {15'h0000, sum_fault_indicator});
        rchk(2, 4'h0, 8'h05);
        rchk(2, 4'h2, 8'h01);
        @(posedge sys_clk) wire_break_pin <= 2'b00;
        edges(3);
        @(posedge sys_clk) diag_clear <= 1'b1;
        @(posedge sys_clk) diag_clear <= 1'b0;
        edges(1);
        chk("fault clr", 16'h0000, {15'h0000, sum_fault_indicator});
        conclude();
    end
endmodule // tb_aio_ctrl
`default_nettype wire
